// file: shared/i2c_pkg.sv
package i2c_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCL_PERIOD_NS = 400;
  localparam int unsigned SCL_QTR_RAW   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int unsigned SCL_QTR_CYC   = (SCL_QTR_RAW < 1) ? 1 : SCL_QTR_RAW;
  localparam logic [7:0]  SCL_QTR_LAST  = 8'(SCL_QTR_CYC - 1);

  // ****************************************
  // device register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_BUF  = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_IRQ  = 8'h10;
  localparam logic [7:0] OFS_DIR  = 8'h14;

  localparam int unsigned CTRL_OV_BIT  = 6;
  localparam int unsigned CTRL_EN_BIT  = 5;
  localparam int unsigned CTRL_CKP_BIT = 4;
  localparam int unsigned STAT_BF_BIT  = 0;
  localparam int unsigned STAT_UA_BIT  = 1;
  localparam int unsigned STAT_RW_BIT  = 2;
  localparam int unsigned STAT_S_BIT   = 3;
  localparam int unsigned STAT_P_BIT   = 4;
  localparam int unsigned STAT_DA_BIT  = 5;
  localparam int unsigned IRQ_BIT      = 3;
  localparam int unsigned DIR_SCL_BIT  = 3;
  localparam int unsigned DIR_SDA_BIT  = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET  = 8'hff;

  localparam logic [3:0] MODE_SLV7    = 4'h6;
  localparam logic [3:0] MODE_SLV10   = 4'h7;
  localparam logic [3:0] MODE_FWM     = 4'hb;
  localparam logic [3:0] MODE_SLV7_SP = 4'he;
  localparam logic [3:0] MODE_SLV10_SP = 4'hf;
  localparam logic [4:0] TEN_HDR      = 5'h1e;

  // ****************************************
  // bus master controller register map
  // ****************************************
  localparam logic [7:0] OFS_HCMD  = 8'h00;
  localparam logic [7:0] OFS_HTXD  = 8'h04;
  localparam logic [7:0] OFS_HRXD  = 8'h08;
  localparam logic [7:0] OFS_HSTAT = 8'h0c;

  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT  = 1;
  localparam int unsigned CMD_WRITE_BIT = 2;
  localparam int unsigned CMD_READ_BIT  = 3;
  localparam int unsigned CMD_NACK_BIT  = 4;
  localparam int unsigned HST_BUSY_BIT  = 0;
  localparam int unsigned HST_NACK_BIT  = 1;
endpackage

// file: shared/i2c_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // open drain with external pull-up: a line is low if any end pulls it low
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport device (
    input  scl,
    input  sda,
    output dev_scl_o,
    output dev_scl_oe,
    output dev_sda_o,
    output dev_sda_oe
  );
  modport host (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface
`default_nettype wire

// file: design/i2c_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_port (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  i2c_link_if.device       link
);
  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_SKIP} slv_state_t;

  function automatic logic mode_slave(input logic [3:0] m);
    return (m == i2c_pkg::MODE_SLV7) || (m == i2c_pkg::MODE_SLV10) ||
           (m == i2c_pkg::MODE_SLV7_SP) || (m == i2c_pkg::MODE_SLV10_SP);
  endfunction
  function automatic logic mode_ten(input logic [3:0] m);
    return (m == i2c_pkg::MODE_SLV10) || (m == i2c_pkg::MODE_SLV10_SP);
  endfunction
  function automatic logic mode_sp(input logic [3:0] m);
    return (m == i2c_pkg::MODE_FWM) || (m == i2c_pkg::MODE_SLV7_SP) ||
           (m == i2c_pkg::MODE_SLV10_SP);
  endfunction

  logic [7:0] ctrl_q;
  logic [7:0] buf_q;
  logic [7:0] addr_q;
  logic [7:0] dir_q;
  logic       bf_q, ua_q, rw_q, s_q, p_q, da_q, irq_q;
  logic [2:0] scl_sh_q, sda_sh_q;
  slv_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic       ack_q, hit_q, rd_q, first_q, low_q, addrb_q, hi_ok_q, ten_ok_q, hold_q;
  logic [3:0] mode;
  logic       active, slave_on, is_ten, full, low_phase, rd_hdr, hit, pin_ok;
  logic       scl_s, scl_p, sda_s, sda_p, scl_rise, scl_fall, start_c, stop_c;
  logic       fall8, fall9, ev_load, ev_ovf, ev_ua, ev_ckclr, ev_rwclr, ev_irq;
  logic       acc, wr, rd, mapped;

  // ****************************************
  // configuration decode
  // ****************************************
  assign mode     = ctrl_q[3:0];
  assign active   = ctrl_q[i2c_pkg::CTRL_EN_BIT] &
                    (mode_slave(mode) | (mode == i2c_pkg::MODE_FWM));
  assign slave_on = active & mode_slave(mode);
  assign is_ten   = mode_ten(mode);
  assign pin_ok   = active & dir_q[i2c_pkg::DIR_SCL_BIT] & dir_q[i2c_pkg::DIR_SDA_BIT];

  // ****************************************
  // pin synchronisers and bus events
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], link.scl};
      sda_sh_q <= {sda_sh_q[1:0], link.sda};
    end
  end
  // bit 0 is the metastable stage; only bits 1 and 2 are looked at
  assign scl_s    = scl_sh_q[1];
  assign scl_p    = scl_sh_q[2];
  assign sda_s    = sda_sh_q[1];
  assign sda_p    = sda_sh_q[2];
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c  = active & scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c   = active & scl_s & scl_p & ~sda_p & sda_s;

  // ****************************************
  // address compare
  // ****************************************
  assign full      = bf_q | ctrl_q[i2c_pkg::CTRL_OV_BIT];
  assign low_phase = is_ten & hi_ok_q;
  assign rd_hdr    = is_ten & ~hi_ok_q & sr_q[0] & ten_ok_q;
  always_comb begin
    if (state_q == S_DATA) begin
      hit = 1'b1;
    end else if (low_phase) begin
      hit = (sr_q == addr_q);
    end else if (is_ten) begin
      hit = (sr_q[7:3] == i2c_pkg::TEN_HDR) & (sr_q[7:1] == addr_q[7:1]) &
            (~sr_q[0] | ten_ok_q);
    end else begin
      hit = (sr_q[7:1] == addr_q[7:1]);
    end
  end
  assign fall8    = slave_on & scl_fall & (cnt_q == 4'h8) &
                    ((state_q == S_ADDR) | (state_q == S_DATA));
  assign fall9    = slave_on & scl_fall & (cnt_q == 4'h9);
  assign ev_load  = fall8 & hit & ~full;
  assign ev_ovf   = fall8 & hit & full;
  assign ev_irq   = fall9 & hit_q;
  assign ev_ua    = fall9 & hit_q & (first_q | low_q);
  assign ev_ckclr = fall9 & hit_q & rd_q;
  assign ev_rwclr = fall9 & ~addrb_q;

  // ****************************************
  // serial engine
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= S_IDLE;
      cnt_q    <= 4'h0;
      sr_q     <= 8'h00;
      ack_q    <= 1'b0;
      hit_q    <= 1'b0;
      rd_q     <= 1'b0;
      first_q  <= 1'b0;
      low_q    <= 1'b0;
      addrb_q  <= 1'b0;
      hi_ok_q  <= 1'b0;
      ten_ok_q <= 1'b0;
    end else if (!slave_on || stop_c) begin
      // disabling the port resets the slave as well
      state_q  <= S_IDLE;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      hi_ok_q  <= 1'b0;
      ten_ok_q <= 1'b0;
    end else if (start_c) begin
      state_q <= S_ADDR;
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      hi_ok_q <= 1'b0;
    end else if (scl_rise && state_q != S_IDLE) begin
      if (cnt_q < 4'h8) begin
        sr_q <= {sr_q[6:0], sda_s};
      end
      if (cnt_q < 4'h9) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else if (fall8) begin
      ack_q   <= hit & ~full;
      hit_q   <= hit;
      addrb_q <= (state_q == S_ADDR);
      rd_q    <= (state_q == S_ADDR) & sr_q[0] & ~low_phase;
      first_q <= (state_q == S_ADDR) & is_ten & ~low_phase & ~rd_hdr;
      low_q   <= (state_q == S_ADDR) & low_phase;
    end else if (fall9) begin
      ack_q <= 1'b0;
      cnt_q <= 4'h0;
      if (!hit_q || rd_q) begin
        // transmit data phase is not carried; wait for the next start
        state_q <= S_SKIP;
      end else if (first_q) begin
        hi_ok_q <= 1'b1;
      end else begin
        state_q <= S_DATA;
        if (low_q) begin
          hi_ok_q  <= 1'b0;
          ten_ok_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // the hold is only applied while the clock is already low, never mid high phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= slave_on & (ua_q | ~ctrl_q[i2c_pkg::CTRL_CKP_BIT]) &
                (hold_q | ~scl_s);
    end
  end
  assign link.dev_scl_o  = 1'b0;
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_scl_oe = pin_ok & hold_q;
  assign link.dev_sda_oe = pin_ok & ack_q;

  // ****************************************
  // register access
  // ****************************************
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign mapped = (paddr == i2c_pkg::OFS_CTRL) | (paddr == i2c_pkg::OFS_STAT) |
                  (paddr == i2c_pkg::OFS_BUF) | (paddr == i2c_pkg::OFS_ADDR) |
                  (paddr == i2c_pkg::OFS_IRQ) | (paddr == i2c_pkg::OFS_DIR);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      i2c_pkg::OFS_CTRL: prdata[7:0] = ctrl_q;
      i2c_pkg::OFS_STAT: prdata[5:0] = {da_q, p_q, s_q, rw_q, ua_q, bf_q};
      i2c_pkg::OFS_BUF:  prdata[7:0] = buf_q;
      i2c_pkg::OFS_ADDR: prdata[7:0] = addr_q;
      i2c_pkg::OFS_IRQ:  prdata[i2c_pkg::IRQ_BIT] = irq_q;
      i2c_pkg::OFS_DIR:  prdata[7:0] = dir_q;
      default:           prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= i2c_pkg::CTRL_RESET;
      addr_q <= i2c_pkg::ADDR_RESET;
      dir_q  <= i2c_pkg::DIR_RESET;
      buf_q  <= 8'h00;
    end else begin
      if (wr && paddr == i2c_pkg::OFS_CTRL) begin
        ctrl_q[6:0] <= pwdata[6:0];
      end
      if (ev_ovf) begin
        ctrl_q[i2c_pkg::CTRL_OV_BIT] <= 1'b1;
      end
      if (ev_ckclr) begin
        ctrl_q[i2c_pkg::CTRL_CKP_BIT] <= 1'b0;
      end
      if (wr && paddr == i2c_pkg::OFS_ADDR) begin
        addr_q <= pwdata[7:0];
      end
      if (wr && paddr == i2c_pkg::OFS_DIR) begin
        dir_q <= pwdata[7:0];
      end
      if (ev_load) begin
        buf_q <= sr_q;
      end else if (wr && paddr == i2c_pkg::OFS_BUF) begin
        buf_q <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // status flags (hardware set wins over clear)
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bf_q  <= 1'b0;
      ua_q  <= 1'b0;
      rw_q  <= 1'b0;
      s_q   <= 1'b0;
      p_q   <= 1'b0;
      da_q  <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (!active) begin
        bf_q <= 1'b0;
        ua_q <= 1'b0;
        rw_q <= 1'b0;
        s_q  <= 1'b0;
        p_q  <= 1'b0;
        da_q <= 1'b0;
      end else begin
        if (ev_load) begin
          bf_q <= 1'b1;
        end else if (rd && paddr == i2c_pkg::OFS_BUF) begin
          bf_q <= 1'b0;
        end
        if (ev_ua) begin
          ua_q <= 1'b1;
        end else if (wr && paddr == i2c_pkg::OFS_ADDR) begin
          ua_q <= 1'b0;
        end
        if (fall8 && hit && state_q == S_ADDR) begin
          rw_q <= sr_q[0];
        end else if (start_c || stop_c || ev_rwclr) begin
          rw_q <= 1'b0;
        end
        if (start_c) begin
          s_q <= 1'b1;
          p_q <= 1'b0;
        end else if (stop_c) begin
          s_q <= 1'b0;
          p_q <= 1'b1;
        end
        if (fall8) begin
          da_q <= (state_q == S_DATA);
        end
      end
      if (ev_irq || (mode_sp(mode) && (start_c || stop_c))) begin
        irq_q <= 1'b1;
      end else if (wr && paddr == i2c_pkg::OFS_IRQ) begin
        irq_q <= pwdata[i2c_pkg::IRQ_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// file: design/i2c_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  i2c_link_if.host         link
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

  host_state_t state_q;
  logic [7:0]  div_q;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [8:0]  sh_q;
  logic [8:0]  rx_q;
  logic [7:0]  txd_q;
  logic        scl_low_q, sda_low_q;
  logic [1:0]  scl_sh_q, sda_sh_q;
  logic        tick, acc, wr, cmd_go, mapped;

  // ****************************************
  // quarter bit divider and pin sampling
  // ****************************************
  assign tick = (div_q == i2c_pkg::SCL_QTR_LAST);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q    <= 8'h00;
      scl_sh_q <= 2'h3;
      sda_sh_q <= 2'h3;
    end else begin
      div_q    <= tick ? 8'h00 : div_q + 8'h01;
      scl_sh_q <= {scl_sh_q[0], link.scl};
      sda_sh_q <= {sda_sh_q[0], link.sda};
    end
  end

  // ****************************************
  // register access
  // ****************************************
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign cmd_go  = wr & (paddr == i2c_pkg::OFS_HCMD) & (state_q == H_IDLE);
  assign mapped  = (paddr == i2c_pkg::OFS_HCMD) | (paddr == i2c_pkg::OFS_HTXD) |
                   (paddr == i2c_pkg::OFS_HRXD) | (paddr == i2c_pkg::OFS_HSTAT);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      i2c_pkg::OFS_HTXD:  prdata[7:0] = txd_q;
      i2c_pkg::OFS_HRXD:  prdata[7:0] = rx_q[8:1];
      i2c_pkg::OFS_HSTAT: prdata[1:0] = {rx_q[0], state_q != H_IDLE};
      default:            prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 8'h00;
    end else if (wr && paddr == i2c_pkg::OFS_HTXD) begin
      txd_q <= pwdata[7:0];
    end
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  // a command written while busy is dropped; software polls the busy bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= H_IDLE;
      ph_q      <= 2'h0;
      bit_q     <= 4'h0;
      sh_q      <= 9'h1ff;
      rx_q      <= 9'h000;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      unique case (state_q)
        H_IDLE: begin
          ph_q  <= 2'h0;
          bit_q <= 4'h0;
          if (cmd_go && pwdata[i2c_pkg::CMD_START_BIT]) begin
            state_q <= H_START;
          end else if (cmd_go && pwdata[i2c_pkg::CMD_STOP_BIT]) begin
            state_q <= H_STOP;
          end else if (cmd_go && pwdata[i2c_pkg::CMD_WRITE_BIT]) begin
            sh_q    <= {txd_q, 1'b1};
            state_q <= H_BIT;
          end else if (cmd_go && pwdata[i2c_pkg::CMD_READ_BIT]) begin
            sh_q    <= {8'hff, pwdata[i2c_pkg::CMD_NACK_BIT]};
            state_q <= H_BIT;
          end
        end
        H_START: begin
          if (ph_q == 2'h0) begin
            sda_low_q <= 1'b0;
            if (tick) begin
              scl_low_q <= 1'b0;
              ph_q      <= 2'h1;
            end
          end else if (ph_q == 2'h1) begin
            if (tick && scl_sh_q[1]) begin
              sda_low_q <= 1'b1;
              ph_q      <= 2'h2;
            end
          end else if (tick) begin
            scl_low_q <= 1'b1;
            state_q   <= H_IDLE;
          end
        end
        H_BIT: begin
          unique case (ph_q)
            2'h0: begin
              sda_low_q <= ~sh_q[8];
              if (tick) begin
                scl_low_q <= 1'b0;
                ph_q      <= 2'h1;
              end
            end
            2'h1: begin
              // the slave may stretch the clock; wait until it is high
              if (tick && scl_sh_q[1]) begin
                rx_q <= {rx_q[7:0], sda_sh_q[1]};
                ph_q <= 2'h2;
              end
            end
            2'h2: begin
              if (tick) begin
                scl_low_q <= 1'b1;
                ph_q      <= 2'h3;
              end
            end
            2'h3: begin
              if (tick) begin
                sh_q  <= {sh_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                ph_q  <= 2'h0;
                if (bit_q == 4'h8) begin
                  sda_low_q <= 1'b0;
                  state_q   <= H_IDLE;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          if (ph_q == 2'h0) begin
            sda_low_q <= 1'b1;
            if (tick) begin
              scl_low_q <= 1'b0;
              ph_q      <= 2'h1;
            end
          end else if (tick && scl_sh_q[1]) begin
            sda_low_q <= 1'b0;
            state_q   <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = scl_low_q;
  assign link.host_sda_oe = sda_low_q;
endmodule
`default_nettype wire

// file: sim/i2c_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// link checks
// ****************************************
module i2c_link_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_sda_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_dev_od; !dev_scl_o && !dev_sda_o; endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives a line high");
  property p_host_od; !host_scl_o && !host_sda_o; endproperty
  a_host_od: assert property (p_host_od) else $error("host drives a line high");
  property p_ack_start; $rose(dev_sda_oe) |-> !scl; endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack begins with clock high");
  property p_ack_end; $fell(dev_sda_oe) |-> !scl; endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack ends with clock high");
  property p_ack_hold; $rose(dev_sda_oe) |=> dev_sda_oe [*4]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
  property p_ack_bound; $rose(dev_sda_oe) |-> ##[1:40] !dev_sda_oe; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack never released");
  // data may only move while the clock is low, else it would fake start or stop
  property p_sda_quiet; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  a_sda_quiet: assert property (p_sda_quiet) else $error("data moved in clock high");
  property p_hold_begin; $rose(dev_scl_oe) |-> $past(!scl); endproperty
  a_hold_begin: assert property (p_hold_begin) else $error("stretch cut a high phase");
  c_ack: cover property ($rose(dev_sda_oe));
  c_hold: cover property ($rose(dev_scl_oe));
  c_start: cover property (scl && $fell(sda));
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module tb;
  logic        clk;
  logic        resetn;
  logic [1:0]  psel, penable, pwrite;
  wire  [1:0]  pready, pslverr;
  logic [7:0]  paddr [2];
  logic [31:0] pwdata [2];
  wire  [31:0] prdata [2];
  logic [31:0] rd, d1;
  logic [15:0] r;
  logic [6:0]  a;
  logic        err;
  int          n_mismatch, checked;
  i2c_link_if link ();
  i2c_slave_port i2c_slave_port_i (.clk(clk), .resetn(resetn), .paddr(paddr[0]),
    .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]), .pwdata(pwdata[0]),
    .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]), .link(link));
  i2c_bus_master i2c_bus_master_i (.clk(clk), .resetn(resetn), .paddr(paddr[1]),
    .psel(psel[1]), .penable(penable[1]), .pwrite(pwrite[1]), .pwdata(pwdata[1]),
    .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]), .link(link));
  i2c_link_checker i2c_link_checker_i (.clk(clk), .resetn(resetn), .scl(link.scl),
    .sda(link.sda), .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .host_scl_o(link.host_scl_o), .host_sda_o(link.host_sda_o));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // enable and clock release set together, else the slave stretches forever
  function automatic logic [31:0] f_ctrl(input logic [3:0] m);
    return {28'h0, m} | (32'h1 << i2c_pkg::CTRL_EN_BIT) | (32'h1 << i2c_pkg::CTRL_CKP_BIT);
  endfunction
  function automatic logic [31:0] f_addr(input logic [6:0] ad, input logic w);
    return {24'h0, ad, w};
  endfunction
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input int h, input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    paddr[h] <= ad;
    pwrite[h] <= w;
    pwdata[h] <= wd;
    psel[h] <= 1'b1;
    @(posedge clk);
    penable[h] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready[h] !== 1'b1 && n < 50);
    rd = prdata[h];
    err = pslverr[h];
    psel[h] <= 1'b0;
    penable[h] <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      results();
    end
  endtask
  // leaves the host status word in rd
  task automatic hcmd(input int bitno);
    int n;
    apb(1, 1'b1, i2c_pkg::OFS_HCMD, 32'h1 << bitno);
    n = 0;
    do begin
      apb(1, 1'b0, i2c_pkg::OFS_HSTAT, 32'h0);
      n++;
    end while (rd[i2c_pkg::HST_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic hsend(input logic [31:0] b);
    apb(1, 1'b1, i2c_pkg::OFS_HTXD, b);
    hcmd(i2c_pkg::CMD_WRITE_BIT);
  endtask
  initial begin
    psel = 2'b0; penable = 2'b0; pwrite = 2'b0; resetn = 1'b0;
    paddr[0] = 8'h0; paddr[1] = 8'h0; pwdata[0] = 32'h0; pwdata[1] = 32'h0;
    n_mismatch = 0; checked = 0; r = 16'd18263; rd = 32'h0; err = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    r = lfsr(r);
    a = r[6:0];
    apb(0, 1'b0, i2c_pkg::OFS_CTRL, 32'h0); chk(rd, 32'h0);
    apb(0, 1'b0, i2c_pkg::OFS_DIR, 32'h0); chk(rd, 32'hff);
    hcmd(i2c_pkg::CMD_START_BIT);
    hsend(f_addr(a, 1'b0)); chk(rd[i2c_pkg::HST_NACK_BIT], 1);
    hcmd(i2c_pkg::CMD_STOP_BIT);
    apb(0, 1'b1, i2c_pkg::OFS_ADDR, f_addr(a, 1'b0));
    apb(0, 1'b1, i2c_pkg::OFS_CTRL, f_ctrl(i2c_pkg::MODE_SLV7));
    hcmd(i2c_pkg::CMD_START_BIT);
    hsend(f_addr(a, 1'b0)); chk(rd[i2c_pkg::HST_NACK_BIT], 0);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_BF_BIT], 1);
    apb(0, 1'b0, i2c_pkg::OFS_IRQ, 32'h0); chk(rd[i2c_pkg::IRQ_BIT], 1);
    apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0); chk(rd, f_addr(a, 1'b0));
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_BF_BIT], 0);
    apb(0, 1'b1, i2c_pkg::OFS_IRQ, 32'h0);
    for (int i = 0; i < 3; i++) begin
      r = lfsr(r);
      d1 = {24'h0, r[7:0]};
      hsend(d1); chk(rd[i2c_pkg::HST_NACK_BIT], 0);
      if (i < 2) begin
        apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0); chk(rd, d1);
      end
    end
    // buffer left full: the next byte must be refused and the old one kept
    apb(0, 1'b1, i2c_pkg::OFS_IRQ, 32'h0);
    hsend({24'h0, ~d1[7:0]}); chk(rd[i2c_pkg::HST_NACK_BIT], 1);
    apb(0, 1'b0, i2c_pkg::OFS_CTRL, 32'h0); chk(rd[i2c_pkg::CTRL_OV_BIT], 1);
    apb(0, 1'b0, i2c_pkg::OFS_IRQ, 32'h0); chk(rd[i2c_pkg::IRQ_BIT], 1);
    apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0); chk(rd, d1);
    hcmd(i2c_pkg::CMD_STOP_BIT);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_P_BIT], 1);
    apb(0, 1'b0, i2c_pkg::OFS_CTRL, 32'h0); chk(rd[i2c_pkg::CTRL_OV_BIT], 1);
    apb(0, 1'b1, i2c_pkg::OFS_CTRL, f_ctrl(i2c_pkg::MODE_SLV7));
    apb(0, 1'b0, i2c_pkg::OFS_CTRL, 32'h0); chk(rd[i2c_pkg::CTRL_OV_BIT], 0);
    hcmd(i2c_pkg::CMD_START_BIT);
    hsend(f_addr(a ^ 7'h01, 1'b0)); chk(rd[i2c_pkg::HST_NACK_BIT], 1);
    hcmd(i2c_pkg::CMD_START_BIT);
    hsend(f_addr(a, 1'b1)); chk(rd[i2c_pkg::HST_NACK_BIT], 0);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_RW_BIT], 1);
    chk({31'h0, link.dev_scl_oe}, 32'h1);
    apb(0, 1'b1, i2c_pkg::OFS_CTRL, f_ctrl(i2c_pkg::MODE_SLV7));
    apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0);
    hcmd(i2c_pkg::CMD_STOP_BIT);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_RW_BIT], 0);
    // 10-bit: firmware swaps header and low byte in the address register
    r = lfsr(r);
    d1 = {24'h0, i2c_pkg::TEN_HDR, r[9:8], 1'b0};
    apb(0, 1'b1, i2c_pkg::OFS_ADDR, d1);
    apb(0, 1'b1, i2c_pkg::OFS_CTRL, f_ctrl(i2c_pkg::MODE_SLV10));
    hcmd(i2c_pkg::CMD_START_BIT);
    hsend(d1); chk(rd[i2c_pkg::HST_NACK_BIT], 0);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_UA_BIT], 1);
    chk({31'h0, link.dev_scl_oe}, 32'h1);
    apb(0, 1'b1, i2c_pkg::OFS_ADDR, {24'h0, r[7:0]});
    apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0); chk(rd, d1);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_UA_BIT], 0);
    hsend({24'h0, r[7:0]}); chk(rd[i2c_pkg::HST_NACK_BIT], 0);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_UA_BIT], 1);
    apb(0, 1'b1, i2c_pkg::OFS_ADDR, d1);
    apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0); chk(rd, {24'h0, r[7:0]});
    chk({31'h0, link.dev_scl_oe}, 32'h0);
    hcmd(i2c_pkg::CMD_START_BIT);
    hsend(d1 | 32'h1); chk(rd[i2c_pkg::HST_NACK_BIT], 0);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[2:0], 32'h5);
    apb(0, 1'b1, i2c_pkg::OFS_CTRL, f_ctrl(i2c_pkg::MODE_SLV10));
    apb(0, 1'b0, i2c_pkg::OFS_BUF, 32'h0); chk(rd, d1 | 32'h1);
    hcmd(i2c_pkg::CMD_STOP_BIT);
    apb(0, 1'b1, i2c_pkg::OFS_CTRL, f_ctrl(i2c_pkg::MODE_FWM));
    apb(0, 1'b1, i2c_pkg::OFS_IRQ, 32'h0);
    hcmd(i2c_pkg::CMD_START_BIT);
    apb(0, 1'b0, i2c_pkg::OFS_IRQ, 32'h0); chk(rd[i2c_pkg::IRQ_BIT], 1);
    hsend(d1); chk(rd[i2c_pkg::HST_NACK_BIT], 1);
    hcmd(i2c_pkg::CMD_STOP_BIT);
    apb(0, 1'b0, i2c_pkg::OFS_STAT, 32'h0); chk(rd[i2c_pkg::STAT_P_BIT], 1);
    apb(0, 1'b0, 8'h20, 32'h0); chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    results();
  end
endmodule
`default_nettype wire
